/* File: src/sdma_consts.svh */
// register map, reset values and field positions of the receive/transmit dma pointers
`ifndef SDMA_CONSTS_SVH
`define SDMA_CONSTS_SVH

`define SDMA_RX_A_START_ADDR  32'h4000c800
`define SDMA_RX_A_END_ADDR    32'h4000c804
`define SDMA_RX_B_START_ADDR  32'h4000c808
`define SDMA_RX_B_END_ADDR    32'h4000c80c
`define SDMA_RX_A_OFFSET_ADDR 32'h4000c820
`define SDMA_RX_B_OFFSET_ADDR 32'h4000c824
`define SDMA_TX_OFFSET_ADDR   32'h4000c828
`define SDMA_RX_SNAPSHOT_ADDR 32'h4000c870
`define SDMA_RX_A_ERROR_ADDR  32'h4000c830
`define SDMA_STATUS_ADDR      32'h4000c8f0

`define SDMA_FIELD_MSB        13
`define SDMA_FIELD_W          14
`define SDMA_FIELD_RESET      14'h0000
`define SDMA_RAM_BASE         32'h20000000
`define SDMA_STAT_LOADED_A    0
`define SDMA_STAT_LOADED_B    1
`define SDMA_STAT_ACTIVE_B    2
`define SDMA_STAT_SAVED       3
`define SDMA_FIFO_DEPTH       16

`endif

/* File: src/sdma_pkg.sv */
// types shared by the dma pointer block
package sdma_pkg;
	// one received byte with its line error flag
	typedef struct packed {
		logic       err;
		logic [7:0] data;
	} rx_word_t;

	// which receive buffer the dma fills
	typedef enum logic {SEL_A, SEL_B} buf_sel_t;
endpackage

/* File: src/serial_dma_buffer_pointers.sv */
// receive fifo and dma buffer pointer logic of a serial controller, wishbone slave
//
// Operation
// - tx offset counts bytes fetched from active transmit buffer start, 14 bits.
// - tx offset clears on transmit buffer load and on dma reset.
// - buffer A start address, 14-bit read-write, reads 0x20000000 after reset.
// - buffer B start address, 14-bit read-write, reads 0x20000000 after reset.
// - buffer A end address holds last byte dma may store there.
// - buffer B end address holds last byte dma may store there.
// - buffer A offset gives where next received byte goes.
// - buffer B offset gives where next received byte goes.
// - each receive offset clears when its buffer loads or dma resets.
// - writing a receive offset while its buffer is unloaded loads it.
// - in spi slave mode, select deassertion snapshots current receive offset.
// - only the first deassertion after reset or receive dma reset is captured; later ones leave snapshot alone.
// - buffer A first error offset records first errored byte, else zero.
`timescale 1ns/10ps
`include "sdma_consts.svh"
`default_nettype none

module sdma_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = `SDMA_FIFO_DEPTH
) (
	input  wire logic             clock,     // system clock
	input  wire logic             srst,      // sync reset, high
	input  wire logic             in_valid,  // writer offers a word
	input  wire logic [WIDTH-1:0] in_data,   // word written
	output var  logic             in_ready,  // room for a word
	output var  logic             out_valid, // word available
	output var  logic [WIDTH-1:0] out_data,  // head word
	input  wire logic             out_ready  // reader takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;
	logic [AW:0]      count_d;

	// handshakes use the registered flags so ready never depends on the reader
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rd_ptr_q];

	// storage, no reset needed on the data itself
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
			end
			if (pop) begin
				rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
			end
			count_q <= count_d;
			in_ready <= (count_d != (AW+1)'(DEPTH));
			out_valid <= (count_d != '0);
		end
	end
endmodule

module serial_dma_buffer_pointers import sdma_pkg::*; #(
	parameter int FIFO_DEPTH = `SDMA_FIFO_DEPTH
) (
	input  wire logic        clock,          // 20 MHz system clock
	input  wire logic        srst,           // sync reset, high
	input  wire logic        wb_cyc_i,       // bus cycle
	input  wire logic        wb_stb_i,       // bus strobe
	input  wire logic        wb_we_i,        // write enable
	input  wire logic [31:0] wb_adr_i,       // byte address
	input  wire logic [3:0]  wb_sel_i,       // byte lanes
	input  wire logic [31:0] wb_dat_i,       // write data
	output var  logic [31:0] wb_dat_o,       // read data
	output var  logic        wb_ack_o,       // acknowledge
	input  wire logic        rx_valid,       // receiver offers a byte
	input  wire rx_word_t    rx_word,        // byte plus error flag
	output var  logic        rx_ready,       // fifo can accept
	output var  logic        ram_we,         // ram write strobe
	output var  logic [13:0] ram_addr,       // ram byte address
	output var  logic [7:0]  ram_wdata,      // ram write byte
	input  wire logic        rx_dma_reset,   // receive dma reset pulse
	input  wire logic        tx_dma_reset,   // transmit dma reset pulse
	input  wire logic        tx_load,        // transmit buffer loaded pulse
	input  wire logic        tx_fetch,       // transmit byte fetched pulse
	input  wire logic        spi_slave_mode, // serial unit in spi slave mode
	input  wire logic        slave_select_n  // select pin, async
);
	logic [13:0] start_a_q;
	logic [13:0] start_b_q;
	logic [13:0] end_a_q;
	logic [13:0] end_b_q;
	logic [13:0] cnt_a_q;
	logic [13:0] cnt_b_q;
	logic [13:0] tx_cnt_q;
	logic [13:0] snap_q;
	logic [13:0] err_a_q;
	logic        err_a_set_q;
	logic        saved_q;
	logic        loaded_a_q;
	logic        loaded_b_q;
	buf_sel_t    active_q;
	logic        ss_meta_q;
	logic        ss_sync_q;
	logic        ss_prev_q;
	logic        wr_commit;
	logic        load_a;
	logic        load_b;
	logic        drain;
	logic        pop;
	logic        done;
	logic [13:0] cur_cnt;
	logic [13:0] cur_start;
	logic [13:0] cur_end;
	logic        fifo_valid;
	rx_word_t    fifo_word;
	logic [31:0] rd_d;
	logic        capture;

	// merge low two byte lanes into a 14-bit field
	function automatic logic [13:0] merge14(input logic [13:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge14 = old;
		if (sel[0]) begin
			merge14[7:0] = d[7:0];
		end
		if (sel[1]) begin
			merge14[13:8] = d[13:8];
		end
	endfunction

	// write takes effect on the edge where the master sees ack
	assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign load_a = wr_commit & (wb_adr_i == `SDMA_RX_A_OFFSET_ADDR) & ~loaded_a_q;
	assign load_b = wr_commit & (wb_adr_i == `SDMA_RX_B_OFFSET_ADDR) & ~loaded_b_q;

	// current buffer view
	assign cur_cnt = (active_q == SEL_A) ? cnt_a_q : cnt_b_q;
	assign cur_start = (active_q == SEL_A) ? start_a_q : start_b_q;
	assign cur_end = (active_q == SEL_A) ? end_a_q : end_b_q;
	// stall the fifo while no buffer is ready, so back-pressure reaches the receiver
	assign drain = ((active_q == SEL_A) ? loaded_a_q : loaded_b_q) & ~rx_dma_reset;
	assign pop = drain & fifo_valid;
	assign done = pop & ((cur_start + cur_cnt) == cur_end);

	sdma_fifo #(
		.WIDTH ($bits(rx_word_t)),
		.DEPTH (FIFO_DEPTH)
	) rx_fifo (
		.clock     (clock),
		.srst      (srst),
		.in_valid  (rx_valid),
		.in_data   (rx_word),
		.in_ready  (rx_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_word),
		.out_ready (drain)
	);

	// bus acknowledge, one cycle after request, dropped the cycle after
	always_ff @(posedge clock) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	// read mux; unmapped addresses read zero but still ack
	always_comb begin
		rd_d = 32'h00000000;
		case (wb_adr_i)
			`SDMA_RX_A_START_ADDR:  rd_d = `SDMA_RAM_BASE | {18'h00000, start_a_q};
			`SDMA_RX_B_START_ADDR:  rd_d = `SDMA_RAM_BASE | {18'h00000, start_b_q};
			`SDMA_RX_A_END_ADDR:    rd_d = `SDMA_RAM_BASE | {18'h00000, end_a_q};
			`SDMA_RX_B_END_ADDR:    rd_d = `SDMA_RAM_BASE | {18'h00000, end_b_q};
			`SDMA_RX_A_OFFSET_ADDR: rd_d = {18'h00000, cnt_a_q};
			`SDMA_RX_B_OFFSET_ADDR: rd_d = {18'h00000, cnt_b_q};
			`SDMA_TX_OFFSET_ADDR:   rd_d = {18'h00000, tx_cnt_q};
			`SDMA_RX_SNAPSHOT_ADDR: rd_d = {18'h00000, snap_q};
			`SDMA_RX_A_ERROR_ADDR:  rd_d = {18'h00000, err_a_q};
			`SDMA_STATUS_ADDR: begin
				rd_d[`SDMA_STAT_LOADED_A] = loaded_a_q;
				rd_d[`SDMA_STAT_LOADED_B] = loaded_b_q;
				rd_d[`SDMA_STAT_ACTIVE_B] = (active_q == SEL_B);
				rd_d[`SDMA_STAT_SAVED] = saved_q;
			end
			default: rd_d = 32'h00000000;
		endcase
	end

	// read data captured with the request so it is stable under ack
	always_ff @(posedge clock) begin
		if (srst) begin
			wb_dat_o <= 32'h00000000;
		end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
			wb_dat_o <= rd_d;
		end
	end

	// start and end addresses; software keeps them sane before loading
	always_ff @(posedge clock) begin
		if (srst) begin
			start_a_q <= `SDMA_FIELD_RESET;
			start_b_q <= `SDMA_FIELD_RESET;
			end_a_q <= `SDMA_FIELD_RESET;
			end_b_q <= `SDMA_FIELD_RESET;
		end else if (wr_commit) begin
			if (wb_adr_i == `SDMA_RX_A_START_ADDR) begin
				start_a_q <= merge14(start_a_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == `SDMA_RX_B_START_ADDR) begin
				start_b_q <= merge14(start_b_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == `SDMA_RX_A_END_ADDR) begin
				end_a_q <= merge14(end_a_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == `SDMA_RX_B_END_ADDR) begin
				end_b_q <= merge14(end_b_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	// loaded flags; a software load beats a dma reset landing in the same cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			loaded_a_q <= 1'b0;
			loaded_b_q <= 1'b0;
		end else begin
			if (load_a) begin
				loaded_a_q <= 1'b1;
			end else if (rx_dma_reset | (done & (active_q == SEL_A))) begin
				loaded_a_q <= 1'b0;
			end
			if (load_b) begin
				loaded_b_q <= 1'b1;
			end else if (rx_dma_reset | (done & (active_q == SEL_B))) begin
				loaded_b_q <= 1'b0;
			end
		end
	end

	// buffer selection: flip after the end byte, or when only the other is ready
	always_ff @(posedge clock) begin
		if (srst | rx_dma_reset) begin
			active_q <= SEL_A;
		end else if (done) begin
			active_q <= (active_q == SEL_A) ? SEL_B : SEL_A;
		end else if (active_q == SEL_A && !loaded_a_q && loaded_b_q) begin
			active_q <= SEL_B;
		end else if (active_q == SEL_B && !loaded_b_q && loaded_a_q) begin
			active_q <= SEL_A;
		end
	end

	// receive offsets; the last value stays readable after unload
	always_ff @(posedge clock) begin
		if (srst | rx_dma_reset) begin
			cnt_a_q <= `SDMA_FIELD_RESET;
			cnt_b_q <= `SDMA_FIELD_RESET;
		end else begin
			if (load_a) begin
				cnt_a_q <= `SDMA_FIELD_RESET;
			end else if (pop & (active_q == SEL_A)) begin
				cnt_a_q <= cnt_a_q + 14'h0001;
			end
			if (load_b) begin
				cnt_b_q <= `SDMA_FIELD_RESET;
			end else if (pop & (active_q == SEL_B)) begin
				cnt_b_q <= cnt_b_q + 14'h0001;
			end
		end
	end

	// ram write port, registered so every output is a flop
	always_ff @(posedge clock) begin
		if (srst) begin
			ram_we <= 1'b0;
			ram_addr <= 14'h0000;
			ram_wdata <= 8'h00;
		end else begin
			ram_we <= pop;
			if (pop) begin
				ram_addr <= cur_start + cur_cnt;
				ram_wdata <= fifo_word.data;
			end
		end
	end

	// first error in buffer A; held until reload or dma reset
	always_ff @(posedge clock) begin
		if (srst | rx_dma_reset | load_a) begin
			err_a_q <= `SDMA_FIELD_RESET;
			err_a_set_q <= 1'b0;
		end else if (pop & (active_q == SEL_A) & fifo_word.err & ~err_a_set_q) begin
			err_a_q <= cnt_a_q;
			err_a_set_q <= 1'b1;
		end
	end

	// transmit offset; load wins over a fetch in the same cycle
	always_ff @(posedge clock) begin
		if (srst | tx_dma_reset | tx_load) begin
			tx_cnt_q <= `SDMA_FIELD_RESET;
		end else if (tx_fetch) begin
			tx_cnt_q <= tx_cnt_q + 14'h0001;
		end
	end

	// select pin synchroniser; only the second stage feeds the edge detect
	always_ff @(posedge clock) begin
		if (srst) begin
			ss_meta_q <= 1'b1;
			ss_sync_q <= 1'b1;
			ss_prev_q <= 1'b1;
		end else begin
			ss_meta_q <= slave_select_n;
			ss_sync_q <= ss_meta_q;
			ss_prev_q <= ss_sync_q;
		end
	end

	assign capture = spi_slave_mode & ss_sync_q & ~ss_prev_q & ~saved_q;

	// snapshot taken once; rearmed only by a receive dma reset or a system reset
	always_ff @(posedge clock) begin
		if (srst) begin
			snap_q <= `SDMA_FIELD_RESET;
			saved_q <= 1'b0;
		end else if (capture) begin
			snap_q <= cur_cnt;
			saved_q <= 1'b1;
		end else if (rx_dma_reset) begin
			saved_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	tx_clear_a: assert property ((tx_load | tx_dma_reset) |=> tx_cnt_q == 14'h0000)
		else $error("tx offset not cleared");
	tx_step_a: assert property ((tx_fetch & ~tx_load & ~tx_dma_reset)
		|=> tx_cnt_q == $past(tx_cnt_q) + 14'h0001)
		else $error("tx offset did not advance");
	start_reset_a: assert property ($fell(srst) |-> start_a_q == 14'h0000
		&& start_b_q == 14'h0000)
		else $error("start addresses not reset");
	end_write_a: assert property ((wr_commit && wb_sel_i == 4'hf
		&& wb_adr_i == `SDMA_RX_B_END_ADDR) |=> end_b_q == $past(wb_dat_i[13:0]))
		else $error("end address B not written");
	offset_step_a: assert property ((pop && active_q == SEL_A && !rx_dma_reset)
		|=> cnt_a_q == $past(cnt_a_q) + 14'h0001)
		else $error("offset A did not advance");
	load_clear_a: assert property ((load_a & ~rx_dma_reset)
		|=> (cnt_a_q == 14'h0000 && loaded_a_q) ##1 (loaded_a_q || $past(done | rx_dma_reset)))
		else $error("load of buffer A wrong");
	unload_end_a: assert property ((done && active_q == SEL_A && !rx_dma_reset)
		|=> !loaded_a_q && active_q == SEL_B)
		else $error("buffer A not unloaded at end");
	snap_take_a: assert property ((capture & ~rx_dma_reset)
		|=> snap_q == $past(cur_cnt) && saved_q)
		else $error("snapshot not taken");
	snap_once_a: assert property ((saved_q & ~rx_dma_reset) |=> $stable(snap_q))
		else $error("snapshot overwritten");
	err_first_a: assert property ((err_a_set_q && !load_a && !rx_dma_reset)
		|=> $stable(err_a_q))
		else $error("first error overwritten");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");

	switch_cover: cover property (done ##[1:40] pop);
	snap_cover: cover property (capture);
	full_cover: cover property (!rx_ready ##1 pop);
	error_cover: cover property (!err_a_set_q ##1 err_a_set_q);
endmodule

`default_nettype wire

/* File: verification/sdma_far_side.sv */
// far side model: serial receiver feeding bytes, and the ram that stores them
`timescale 1ns/10ps
`default_nettype none
module sdma_far_side import sdma_pkg::*; (
	input  wire logic        clock,     // system clock
	input  wire logic        srst,      // sync reset, high
	input  wire logic [7:0]  limit,     // offer bytes below this count
	input  wire logic        pause,     // receiver stall
	input  wire logic        err_on,    // flag line errors
	input  wire logic [7:0]  err_at,    // first errored byte value
	input  wire logic        rx_ready,  // block takes a byte
	output var  logic        rx_valid,  // byte offered
	output var  rx_word_t    rx_word,   // byte and error flag
	input  wire logic        ram_we,    // store strobe
	input  wire logic [13:0] ram_addr,  // store address
	input  wire logic [7:0]  ram_wdata, // stored byte
	output var  logic [7:0]  sent,      // bytes accepted
	output var  logic [7:0]  stored     // bytes written to ram
);
	logic [7:0] mem [0:16383];
	logic [7:0] nxt;
	logic       go;

	// byte value equals its running count, so the bench can predict it
	assign nxt = sent + {7'h00, rx_valid & rx_ready};
	assign go = !pause && (nxt < limit);

	// offer held until taken; idle data toggles so a stale byte never passes for new
	always_ff @(posedge clock) begin
		if (srst) begin
			rx_valid <= 1'b0;
			sent <= 8'h00;
			rx_word <= '0;
		end else begin
			sent <= nxt;
			if (!rx_valid || rx_ready) begin
				rx_valid <= go;
				rx_word.data <= go ? nxt : ~rx_word.data;
				rx_word.err <= err_on && (nxt == err_at || nxt == err_at + 8'h04);
			end
		end
	end

	// ram accepts every store; it has no way to stall
	always_ff @(posedge clock) begin
		if (srst) begin
			stored <= 8'h00;
		end else if (ram_we) begin
			mem[ram_addr] <= ram_wdata;
			stored <= stored + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* File: verification/serial_dma_buffer_pointers_bench.sv */
// self-checking bench of the dma pointer block
`timescale 1ns/10ps
`default_nettype none
`include "sdma_consts.svh"
module serial_dma_buffer_pointers_bench import sdma_pkg::*;;
	localparam logic [31:0] a_st = `SDMA_RX_A_START_ADDR;
	localparam logic [31:0] a_of = `SDMA_RX_A_OFFSET_ADDR;
	localparam logic [31:0] b_of = `SDMA_RX_B_OFFSET_ADDR;
	localparam logic [31:0] tx_a = `SDMA_TX_OFFSET_ADDR;
	localparam logic [31:0] sn_a = `SDMA_RX_SNAPSHOT_ADDR;
	localparam logic [31:0] er_a = `SDMA_RX_A_ERROR_ADDR;
	localparam logic [31:0] st_a = `SDMA_STATUS_ADDR;
	logic        clock = 0, srst = 1, cyc = 0, stb = 0, we = 0;
	logic [31:0] adr = 0, wdat = 0, rdat, ack_dat, v, sa;
	logic [3:0]  sel = 0;
	logic        ack, rx_valid, rx_ready, ram_we;
	rx_word_t    rx_word;
	logic [13:0] ram_addr;
	logic [7:0]  ram_wdata, sent, stored;
	logic        rxr = 0, txr = 0, tld = 0, tft = 0, spim = 0, ssn = 1;
	logic [7:0]  limit = 0, err_at = 0;
	logic        pause = 0, err_on = 0;
	logic [31:0] seed = 32'd84908;
	int          miscompares = 0, n_checks = 0, cyc_n = 0, n;

	serial_dma_buffer_pointers i_dut (.clock(clock), .srst(srst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(ack_dat), .wb_ack_o(ack), .rx_valid(rx_valid), .rx_word(rx_word),
		.rx_ready(rx_ready), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.rx_dma_reset(rxr), .tx_dma_reset(txr), .tx_load(tld), .tx_fetch(tft),
		.spi_slave_mode(spim), .slave_select_n(ssn));
	sdma_far_side u_far (.clock(clock), .srst(srst), .limit(limit), .pause(pause),
		.err_on(err_on), .err_at(err_at), .rx_ready(rx_ready), .rx_valid(rx_valid),
		.rx_word(rx_word), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.sent(sent), .stored(stored));

	// free-running 20 MHz clock
	always #25 clock = ~clock;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one classic cycle; request held until ack is sampled at an edge
	task automatic wb(logic w, logic [31:0] a, logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do @(posedge clock); while (ack !== 1'b1);
		rdat = ack_dat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clock);
	endtask

	task automatic rd(logic [31:0] a, logic [31:0] e, string nm);
		wb(0, a, 0);
		chk(nm, e, rdat);
	endtask

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clock) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			miscompares++;
			close_out();
		end
	end

	initial begin
		repeat (10) @(posedge clock);
		srst <= 0;
		@(posedge clock);
		for (int i = 0; i < 4; i++) rd(a_st + 4 * i, `SDMA_RAM_BASE, "bound reset");
		rd(a_of, 0, "offset a reset");
		rd(b_of, 0, "offset b reset");
		rd(tx_a, 0, "tx reset");
		rd(sn_a, 0, "snapshot reset");
		rd(er_a, 0, "error reset");
		rd(32'h4000c8fc, 0, "unmapped");
		$display("test reset values done");
		// random bounds with junk above the field; read-only offset ignores writes
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			wb(1, a_st + 4 * i, v);
			rd(a_st + 4 * i, `SDMA_RAM_BASE | (v & 32'h3fff), "bound rw");
		end
		wb(1, tx_a, 32'h5);
		rd(tx_a, 0, "tx read only");
		$display("test register access done");
		// two short buffers filled back to back with a stalling receiver
		sa = rnd() & 32'h1fff;
		wb(1, a_st, sa);
		wb(1, a_st + 4, sa + 3);
		wb(1, a_st + 8, sa + 32'h40);
		wb(1, a_st + 12, sa + 32'h45);
		wb(1, a_of, 0);
		wb(1, b_of, 0);
		wb(0, st_a, 0);
		chk("loaded", 3, rdat & 3);
		limit <= 10;
		while (stored < 10) begin
			pause <= ^rnd();
			@(posedge clock);
		end
		pause <= 0;
		for (int i = 0; i < 10; i++)
			chk("ram", i, {24'h0, u_far.mem[14'(i < 4 ? sa + i : sa + 32'h3c + i)]});
		rd(a_of, 4, "offset a");
		rd(b_of, 6, "offset b");
		wb(0, st_a, 0);
		chk("unloaded", 0, rdat & 3);
		$display("test ping pong done");
		// fifo fills with no buffer loaded, then drains into a reloaded buffer
		err_on <= 1;
		err_at <= 15;
		limit <= 30;
		repeat (40) @(posedge clock);
		chk("fifo taken", 26, sent);
		chk("fifo full", 0, rx_ready);
		sa = sa + 32'h100;
		wb(1, a_st, sa);
		wb(1, a_st + 4, sa + 99);
		wb(1, a_of, 32'h7);
		while (stored < 30) begin
			pause <= ^rnd();
			@(posedge clock);
		end
		pause <= 0;
		for (int i = 0; i < 20; i++) chk("ram", 10 + i, {24'h0, u_far.mem[14'(sa + i)]});
		rd(a_of, 20, "offset reload");
		rd(er_a, 5, "first error");
		$display("test fifo done");
		// snapshot once on select release, later releases ignored
		spim <= 1;
		ssn <= 0;
		repeat (4) @(posedge clock);
		ssn <= 1;
		repeat (8) @(posedge clock);
		rd(sn_a, 20, "snapshot");
		limit <= 33;
		while (stored < 33) @(posedge clock);
		rd(a_of, 23, "offset a");
		ssn <= 0;
		repeat (4) @(posedge clock);
		ssn <= 1;
		repeat (8) @(posedge clock);
		rd(sn_a, 20, "snapshot kept");
		rd(st_a, 32'h9, "status saved");
		rxr <= 1;
		@(posedge clock);
		rxr <= 0;
		@(posedge clock);
		rd(a_of, 0, "offset dma reset");
		rd(er_a, 0, "error dma reset");
		rd(st_a, 0, "status dma reset");
		$display("test snapshot done");
		// transmit offset: count fetches, cleared by load and by reset
		for (int k = 0; k < 4; k++) begin
			n = int'(rnd() % 7);
			tld <= 1;
			@(posedge clock);
			tld <= 0;
			for (int j = 0; j < n; j++) begin
				@(posedge clock);
				tft <= 1;
				@(posedge clock);
				tft <= 0;
			end
			@(posedge clock);
			rd(tx_a, n, "tx offset");
		end
		tld <= 1;
		tft <= 1;
		@(posedge clock);
		tld <= 0;
		tft <= 0;
		@(posedge clock);
		rd(tx_a, 0, "tx load wins");
		tft <= 1;
		@(posedge clock);
		tft <= 0;
		txr <= 1;
		@(posedge clock);
		txr <= 0;
		@(posedge clock);
		rd(tx_a, 0, "tx dma reset");
		$display("test tx offset done");
		close_out();
	end
endmodule
`default_nettype wire
